// ---- common/sensor_log_scheduler_regs.vh ----
// register map, field positions, reset values and timing counts of the log scheduler
// assumes APB byte addresses with one aligned 32-bit word per register
`ifndef SENSOR_LOG_SCHEDULER_REGS_VH
`define SENSOR_LOG_SCHEDULER_REGS_VH

`define REG_CTRL 8'h00
`define REG_FORM_BYTE 8'h04
`define REG_STORE_BYTE 8'h08
`define REG_INTERVAL 8'h0C
`define REG_DELAY 8'h10
`define REG_APPBLK 8'h14
`define REG_STATUS 8'h18
`define REG_POINTER 8'h1C
`define REG_MEASUREMENT_COUNT 8'h20

`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_RTOSC 2
`define CTRL_EXTCMP 3
`define CTRL_TEMP 4
`define CTRL_EXT 5
`define CTRL_BATT 6

`define FORM_FMT 0
`define FORM_LO 4
`define FORM_HI 5
`define STORE_MODE 6

`define CTRL_RST 32'h0000_0000
`define BYTE_RST 8'h00
`define INTERVAL_RST 16'h0000
`define DELAY_RST 12'h000
`define APPBLK_RST 8'h00

`define LOG_START_BYTE 14'h0004
`define APP_BLOCK_BYTES 14'h0004
`define LOG_END_BIT_DEF 9216

`define CLK_MHZ 200
`define RTC_STEP_S 1
`define DELAY_STEP_S 512
`define INTERVAL_MAX_S 32768
`define PHASE_CYCLES_DEF 8
`define RESET_INIT_CYCLES_DEF 16

`define SRC_TIMER 2'b00
`define SRC_EXT 2'b01
`define SRC_DIN 2'b10

`endif

// ---- rtl/sensor_log_scheduler.v ----
// logging control of a sensor tag: power modes, log form decode, timers, din start
// assumes synchronous inputs at 200 MHz and an APB master on the register port
//
// Behaviour
// - ring oscillator on in command mode, during logging and reset initialisation
// - battery-check phase alone powers the coarse check circuits, no converter
// - measure phase alone powers sensors without battery check, for temp and ext
// - battery voltage conversion raises battery-check and measure power together
// - otherwise ring oscillator off and low-power indication raised
// - in low power only enabled real-time oscillator and comparator keep running
// - logging form taken from bits 4 and 5 of the form parameter byte
// - form 00 logs every event, no count and no clock value
// - form 01 logs every event, 10-bit, clock value and source code 00, 01 or 10
// - form 10 logs only on a limit hit, 10-bit, with measurement counter
// - form 11 logs only on a changed limit result, 10-bit, with counter
// - storage mode taken from bit 6 of the storage parameter byte
// - storage mode 0 drops entries once the log area is full
// - interval timer steps one second, up to 32768 seconds
// - 12-bit start delay in 512-second steps, counted from entering wait
// - in wait, pull-up on din and falling edge moves to active
// - in active, pull-up on din and each falling edge starts or queues one log event
// - log start address from block count, byte 0x004 when count is zero
// - each entry packed at the first free bit above the previous one, or at the area base on a storage mode 1 wrap
// - 8-bit values only in form 00 with format option 0, else 10 bits
// - one event arriving during a log operation is queued and run after it, a later one replaces it
`timescale 1ns/1ps
`include "sensor_log_scheduler_regs.vh"

module sensor_log_scheduler #(
	parameter CLK_PER_SEC = `CLK_MHZ * 1000000 * `RTC_STEP_S,
	parameter PHASE_CYCLES = `PHASE_CYCLES_DEF,
	parameter RESET_INIT_CYCLES = `RESET_INIT_CYCLES_DEF,
	parameter LOG_END_BIT = `LOG_END_BIT_DEF
)(
	input wire clk,
	input wire sys_rst,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire cmdMode,
	input wire dinPin,
	input wire extIrq,
	input wire [2:0] tempLimit,
	input wire [2:0] extLimit,
	output reg ringOscEn,
	output reg lowPower,
	output reg battCheckPwr,
	output reg measurePwr,
	output reg rtOscRun,
	output reg extCmpRun,
	output reg dinPullup,
	output reg logWrite,
	output reg [13:0] logBitAddr,
	output reg [6:0] logBitLen,
	output reg [1:0] logSrc,
	output reg [15:0] logStamp,
	output reg logWidth10
);

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_WAIT = 2'b01;
	localparam [1:0] ST_ACTIVE = 2'b10;
	localparam [2:0] OP_IDLE = 3'b000;
	localparam [2:0] OP_BCHK = 3'b001;
	localparam [2:0] OP_MEAS = 3'b010;
	localparam [2:0] OP_BATT = 3'b011;
	localparam [2:0] OP_PACK = 3'b100;
	// limits worked out at 32 bits, then cut to the counter widths
	localparam [31:0] PRE_FULL = CLK_PER_SEC - 1;
	localparam [31:0] PH_FULL = PHASE_CYCLES - 1;
	localparam [31:0] INIT_FULL = RESET_INIT_CYCLES - 1;
	localparam [31:0] DSTEP_FULL = `DELAY_STEP_S - 1;
	localparam [31:0] IVL_FULL = `INTERVAL_MAX_S;
	localparam [31:0] END_FULL = LOG_END_BIT;
	localparam [27:0] PRE_MAX = PRE_FULL[27:0];
	localparam [7:0] PH_MAX = PH_FULL[7:0];
	localparam [7:0] INIT_MAX = INIT_FULL[7:0];
	localparam [8:0] DSTEP_MAX = DSTEP_FULL[8:0];
	localparam [16:0] IVL_MAX = IVL_FULL[16:0];
	localparam [14:0] END_BIT = END_FULL[14:0];

	reg [31:0] ctrl_r;
	reg [7:0] formByte_r;
	reg [7:0] storeByte_r;
	reg [15:0] interval_r;
	reg [11:0] delay_r;
	reg [7:0] appBlk_r;
	reg [1:0] state_r;
	reg [2:0] op_r;
	reg [7:0] phCnt_r;
	reg [7:0] initCnt_r;
	reg initDone_r;
	reg [27:0] preCnt_r;
	reg secTick_r;
	reg [16:0] ivlCnt_r;
	reg [8:0] dSecCnt_r;
	reg [11:0] dBlkCnt_r;
	reg dinS1_r;
	reg dinS2_r;
	reg dinS3_r;
	reg pend_r;
	reg [1:0] pendSrc_r;
	reg [1:0] curSrc_r;
	reg [2:0] prevTemp_r;
	reg [2:0] prevExt_r;
	reg [13:0] ptr_r;
	reg full_r;
	reg wrapped_r;
	reg [15:0] measurement_count_r;
	reg [31:0] rdData;
	reg rdOk;
	reg [2:0] opNext;
	reg doLog;
	reg [14:0] ptrEnd;

	wire [1:0] form = formByte_r[`FORM_HI:`FORM_LO];
	wire fmtOpt = formByte_r[`FORM_FMT];
	wire storeMode = storeByte_r[`STORE_MODE];
	wire wrEn = psel & penable & pready & pwrite;
	wire rdReq = psel & penable & ~pready;
	wire dinFall = dinS3_r & ~dinS2_r;
	wire useTemp = ctrl_r[`CTRL_TEMP];
	wire useExt = ctrl_r[`CTRL_EXT];
	wire useBatt = ctrl_r[`CTRL_BATT];
	wire extEvt = extIrq & ctrl_r[`CTRL_EXTCMP] & (form == 2'b01);
	wire ivlEvt = secTick_r & (interval_r != 16'h0000) & (ivlCnt_r + 17'h0_0001 >= {1'b0, interval_r});
	wire actEvt = (state_r == ST_ACTIVE) & (dinFall | ivlEvt | extEvt);
	wire [1:0] evtSrc = dinFall ? `SRC_DIN : (extEvt ? `SRC_EXT : `SRC_TIMER);
	wire [13:0] startBit = (`LOG_START_BYTE + {6'h00, appBlk_r} * `APP_BLOCK_BYTES) << 3;

	// sample width: 8 bits only in dense form with format option clear
	function [3:0] sampleBits;
		input [1:0] f;
		input o;
		begin
			sampleBits = (f == 2'b00 && !o) ? 4'd8 : 4'd10;
		end
	endfunction

	// entry length: samples, then clock and source, or counter
	function [6:0] entryBits;
		input [1:0] f;
		input o;
		input [1:0] n;
		reg [6:0] len;
		begin
			len = {3'b000, sampleBits(f, o)} * {5'b00000, n};
			if (f == 2'b01)
				len = len + 7'd32;
			if (f[1])
				len = len + 7'd16;
			entryBits = len;
		end
	endfunction

	wire [1:0] nSamp = {1'b0, useTemp} + {1'b0, useExt} + {1'b0, useBatt};
	wire [6:0] curLen = entryBits(form, fmtOpt, nSamp);

	// apb: one wait state, writes land on the completing edge
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (rdReq)
		begin
			pready <= 1'b1;
			pslverr <= ~rdOk;
			prdata <= pwrite ? 32'h0000_0000 : rdData;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always @*
	begin
		rdOk = 1'b1;
		rdData = 32'h0000_0000;
		case (paddr)
			`REG_CTRL: rdData = {25'h000_0000, ctrl_r[6:2], 2'b00};
			`REG_FORM_BYTE: rdData = {24'h00_0000, formByte_r};
			`REG_STORE_BYTE: rdData = {24'h00_0000, storeByte_r};
			`REG_INTERVAL: rdData = {16'h0000, interval_r};
			`REG_DELAY: rdData = {20'h0_0000, delay_r};
			`REG_APPBLK: rdData = {24'h00_0000, appBlk_r};
			`REG_STATUS: rdData = {20'h0_0000, curLen, wrapped_r, full_r, pend_r, op_r != OP_IDLE, state_r == ST_ACTIVE};
			`REG_POINTER: rdData = {18'h0_0000, ptr_r};
			`REG_MEASUREMENT_COUNT: rdData = {16'h0000, measurement_count_r};
			default: rdOk = 1'b0;
		endcase
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_r <= `CTRL_RST;
			formByte_r <= `BYTE_RST;
			storeByte_r <= `BYTE_RST;
			interval_r <= `INTERVAL_RST;
			delay_r <= `DELAY_RST;
			appBlk_r <= `APPBLK_RST;
		end
		else if (wrEn)
		begin
			case (paddr)
				`REG_CTRL: ctrl_r <= pwdata;
				`REG_FORM_BYTE: formByte_r <= pwdata[7:0];
				`REG_STORE_BYTE: storeByte_r <= pwdata[7:0];
				`REG_INTERVAL: interval_r <= ({1'b0, pwdata[15:0]} > IVL_MAX) ? IVL_MAX[15:0] : pwdata[15:0];
				`REG_DELAY: delay_r <= pwdata[11:0];
				`REG_APPBLK: appBlk_r <= pwdata[7:0];
				default: ctrl_r <= ctrl_r;
			endcase
		end
		else
			ctrl_r[`CTRL_STOP:`CTRL_START] <= 2'b00;
	end

	// seconds come from a prescaled clk standing in for the calibrated rc oscillator
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			preCnt_r <= 28'h000_0000;
			secTick_r <= 1'b0;
		end
		else
		begin
			secTick_r <= (preCnt_r == PRE_MAX);
			preCnt_r <= (preCnt_r == PRE_MAX) ? 28'h000_0000 : preCnt_r + 28'h000_0001;
		end
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			dinS1_r <= 1'b1;
			dinS2_r <= 1'b1;
			dinS3_r <= 1'b1;
			initCnt_r <= 8'h00;
			initDone_r <= 1'b0;
		end
		else
		begin
			dinS1_r <= dinPin;
			dinS2_r <= dinS1_r;
			dinS3_r <= dinS2_r;
			if (!initDone_r)
			begin
				initCnt_r <= initCnt_r + 8'h01;
				initDone_r <= (initCnt_r == INIT_MAX);
			end
		end
	end

	// device state and timers
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			ivlCnt_r <= 17'h0_0000;
			dSecCnt_r <= 9'h000;
			dBlkCnt_r <= 12'h000;
		end
		else if (ctrl_r[`CTRL_STOP])
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					dSecCnt_r <= 9'h000;
					dBlkCnt_r <= 12'h000;
					ivlCnt_r <= 17'h0_0000;
					if (ctrl_r[`CTRL_START])
						state_r <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (secTick_r && delay_r != 12'h000)
					begin
						dSecCnt_r <= (dSecCnt_r == DSTEP_MAX) ? 9'h000 : dSecCnt_r + 9'h001;
						if (dSecCnt_r == DSTEP_MAX)
							dBlkCnt_r <= dBlkCnt_r + 12'h001;
					end
					if (dinFall)
						state_r <= ST_ACTIVE;
					else if (delay_r != 12'h000 && dBlkCnt_r == delay_r)
						state_r <= ST_ACTIVE;
				end
				ST_ACTIVE:
				begin
					if (ivlEvt)
						ivlCnt_r <= 17'h0_0000;
					else if (secTick_r)
						ivlCnt_r <= ivlCnt_r + 17'h0_0001;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always @*
	begin
		opNext = OP_PACK;
		if (op_r == OP_BCHK && (useTemp || useExt))
			opNext = OP_MEAS;
		else if ((op_r == OP_BCHK || op_r == OP_MEAS) && useBatt)
			opNext = OP_BATT;
	end

	always @*
	begin
		case (form)
			2'b10: doLog = (tempLimit != 3'b000) || (extLimit != 3'b000);
			2'b11: doLog = (tempLimit != prevTemp_r) || (extLimit != prevExt_r);
			default: doLog = 1'b1;
		endcase
		ptrEnd = {1'b0, ptr_r} + {8'h00, curLen};
	end

	// log operation sequence with a one-deep queue
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			op_r <= OP_IDLE;
			phCnt_r <= 8'h00;
			pend_r <= 1'b0;
			pendSrc_r <= `SRC_TIMER;
			curSrc_r <= `SRC_TIMER;
			prevTemp_r <= 3'b000;
			prevExt_r <= 3'b000;
			ptr_r <= 14'h0000;
			full_r <= 1'b0;
			wrapped_r <= 1'b0;
			measurement_count_r <= 16'h0000;
			logWrite <= 1'b0;
			logBitAddr <= 14'h0000;
			logBitLen <= 7'h00;
			logSrc <= `SRC_TIMER;
			logStamp <= 16'h0000;
			logWidth10 <= 1'b0;
		end
		else
		begin
			logWrite <= 1'b0;
			if (state_r == ST_IDLE && ctrl_r[`CTRL_START])
			begin
				ptr_r <= startBit;
				full_r <= 1'b0;
				wrapped_r <= 1'b0;
				measurement_count_r <= 16'h0000;
				prevTemp_r <= 3'b000;
				prevExt_r <= 3'b000;
			end
			case (op_r)
				OP_IDLE:
				begin
					phCnt_r <= 8'h00;
					if (pend_r)
					begin
						op_r <= OP_BCHK;
						curSrc_r <= pendSrc_r;
						pend_r <= actEvt;
						pendSrc_r <= evtSrc;
					end
					else if (actEvt)
					begin
						op_r <= OP_BCHK;
						curSrc_r <= evtSrc;
					end
				end
				OP_BCHK, OP_MEAS, OP_BATT:
				begin
					if (actEvt)
					begin
						pend_r <= 1'b1;
						pendSrc_r <= evtSrc;
					end
					phCnt_r <= (phCnt_r == PH_MAX) ? 8'h00 : phCnt_r + 8'h01;
					if (phCnt_r == PH_MAX)
						op_r <= opNext;
				end
				OP_PACK:
				begin
					if (actEvt)
					begin
						pend_r <= 1'b1;
						pendSrc_r <= evtSrc;
					end
					op_r <= OP_IDLE;
					prevTemp_r <= tempLimit;
					prevExt_r <= extLimit;
					if (measurement_count_r != 16'hFFFF)
						measurement_count_r <= measurement_count_r + 16'h0001;
					logSrc <= curSrc_r;
					logStamp <= measurement_count_r;
					logBitLen <= curLen;
					logWidth10 <= (sampleBits(form, fmtOpt) == 4'd10);
					if (doLog)
					begin
						if (ptrEnd > END_BIT && !storeMode)
							full_r <= 1'b1;
						else if (ptrEnd > END_BIT)
						begin
							// mode 1 behaviour is unspecified here; restart at the area base
							wrapped_r <= 1'b1;
							logWrite <= 1'b1;
							logBitAddr <= startBit;
							ptr_r <= startBit + {7'h00, curLen};
						end
						else
						begin
							logWrite <= 1'b1;
							logBitAddr <= ptr_r;
							ptr_r <= ptrEnd[13:0];
						end
					end
				end
				default: op_r <= OP_IDLE;
			endcase
		end
	end

	// power outputs; sensor supplies only inside a log operation
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ringOscEn <= 1'b1;
			lowPower <= 1'b0;
			battCheckPwr <= 1'b0;
			measurePwr <= 1'b0;
			rtOscRun <= 1'b0;
			extCmpRun <= 1'b0;
			dinPullup <= 1'b0;
		end
		else
		begin
			ringOscEn <= cmdMode | (op_r != OP_IDLE) | ~initDone_r | pend_r;
			lowPower <= ~(cmdMode | (op_r != OP_IDLE) | ~initDone_r | pend_r);
			battCheckPwr <= (op_r == OP_BCHK) | (op_r == OP_BATT);
			measurePwr <= (op_r == OP_MEAS) | (op_r == OP_BATT);
			rtOscRun <= ctrl_r[`CTRL_RTOSC];
			extCmpRun <= ctrl_r[`CTRL_EXTCMP];
			dinPullup <= (state_r == ST_WAIT) | (state_r == ST_ACTIVE);
		end
	end

endmodule

// ---- bench/din_button_model.sv ----
// push button on the digital input pin, grounded while pressed
// assumes press is a one-cycle request from the bench
`timescale 1ns/1ps
module din_button_model (
	input wire clk,
	input wire press,
	input wire dinPullup,
	output wire dinPin
);
	logic [2:0] holdCnt = 3'h0;
	always @(posedge clk)
	begin
		if (press)
			holdCnt <= 3'h4;
		else if (holdCnt != 3'h0)
			holdCnt <= holdCnt - 3'h1;
	end
	// without the pull-up nothing holds the pin up: it reads low
	assign dinPin = (holdCnt != 3'h0) ? 1'b0 : dinPullup;
endmodule

// ---- bench/sensor_log_scheduler_properties.sv ----
// port checker of the log scheduler: power modes, apb timing, log entries
// assumes one clock and the synchronous active-high reset of the design
`timescale 1ns/1ps
module sensor_log_scheduler_checker #(
	parameter LOG_END_BIT = 9216
)(
	input wire clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire cmdMode,
	input wire ringOscEn,
	input wire lowPower,
	input wire battCheckPwr,
	input wire measurePwr,
	input wire dinPullup,
	input wire logWrite,
	input wire [13:0] logBitAddr,
	input wire [6:0] logBitLen,
	input wire [1:0] logSrc,
	input wire logWidth10
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_init_osc_on:
	assert property ($fell(sys_rst) |-> ringOscEn [*8]) else $error("ring osc off in init");
	a_cmd_osc_on:
	assert property (cmdMode |-> ##[0:2] ringOscEn) else $error("ring osc off in command mode");
	a_lowpow_inverse:
	assert property (lowPower != ringOscEn) else $error("low power equals ring osc enable");
	a_lowpow_no_sensor:
	assert property (lowPower |-> !battCheckPwr && !measurePwr) else $error("sensor powered in low power");
	a_apb_one_wait:
	assert property ($rose(penable) && psel |=> pready ##1 !pready) else $error("apb answer timing");
	a_err_with_ready:
	assert property (pslverr |-> pready) else $error("slave error without ready");
	a_write_single:
	assert property (logWrite |=> !logWrite) else $error("log write longer than one cycle");
	a_write_active:
	assert property (logWrite |-> ringOscEn && dinPullup) else $error("log write outside active logging");
	a_narrow_dense:
	assert property (logWrite && !logWidth10 |-> logBitLen % 8 == 0) else $error("narrow entry has extra fields");
	a_src_legal:
	assert property (logWrite |-> logSrc != 2'b11) else $error("illegal source code");
	a_area_bound:
	assert property (logWrite |-> ({18'h0, logBitAddr} + logBitLen) <= LOG_END_BIT) else $error("entry past log area");
	c_wide_write: cover property (logWrite && logWidth10);
	c_batt_conv: cover property (battCheckPwr && measurePwr);
	c_bad_addr: cover property (pslverr);
endmodule
bind sensor_log_scheduler sensor_log_scheduler_checker #(.LOG_END_BIT(LOG_END_BIT)) u_chk (.clk(clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .cmdMode(cmdMode),
	.ringOscEn(ringOscEn), .lowPower(lowPower), .battCheckPwr(battCheckPwr), .measurePwr(measurePwr),
	.dinPullup(dinPullup), .logWrite(logWrite), .logBitAddr(logBitAddr), .logBitLen(logBitLen),
	.logSrc(logSrc), .logWidth10(logWidth10));

// ---- bench/sensor_log_scheduler_tb.sv ----
// self-checking bench of the log scheduler over apb with a button model
// assumes a short second (20 cycles) and a small log area (320 bits)
`timescale 1ns/1ps
`include "sensor_log_scheduler_regs.vh"
module sensor_log_scheduler_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, lastErr;
	logic cmdMode = 1'b0, extIrq = 1'b0, btn = 1'b0;
	logic [2:0] tempLimit = 3'h0, extLimit = 3'h0;
	logic dinPin, ringOscEn, lowPower, battCheckPwr, measurePwr, rtOscRun, extCmpRun, dinPullup;
	logic logWrite, logWidth10;
	logic [13:0] logBitAddr;
	logic [6:0] logBitLen;
	logic [1:0] logSrc;
	logic [15:0] logStamp;
	logic sawB = 1'b0, sawM = 1'b0, sawBoth = 1'b0;
	int numErrors = 0, nTests = 0, wrCnt = 0;
	always #2.5 clk = ~clk;
	sensor_log_scheduler #(.CLK_PER_SEC(20), .LOG_END_BIT(320)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmdMode(cmdMode), .dinPin(dinPin), .extIrq(extIrq),
		.tempLimit(tempLimit), .extLimit(extLimit), .ringOscEn(ringOscEn), .lowPower(lowPower),
		.battCheckPwr(battCheckPwr), .measurePwr(measurePwr), .rtOscRun(rtOscRun), .extCmpRun(extCmpRun),
		.dinPullup(dinPullup), .logWrite(logWrite), .logBitAddr(logBitAddr), .logBitLen(logBitLen),
		.logSrc(logSrc), .logStamp(logStamp), .logWidth10(logWidth10));
	din_button_model u_btn (.clk(clk), .press(btn), .dinPullup(dinPullup), .dinPin(dinPin));
	always @(posedge clk)
	begin
		if (logWrite === 1'b1)
			wrCnt <= wrCnt + 1;
		if (battCheckPwr === 1'b1 && measurePwr === 1'b0)
			sawB = 1'b1;
		if (battCheckPwr === 1'b0 && measurePwr === 1'b1)
			sawM = 1'b1;
		if (battCheckPwr === 1'b1 && measurePwr === 1'b1)
			sawBoth = 1'b1;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp)
		begin
			numErrors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is sampled high, then released
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			numErrors++;
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task press;
		@(posedge clk);
		btn <= 1'b1;
		@(posedge clk);
		btn <= 1'b0;
	endtask
	task waitWr(input int n);
		int k;
		k = 0;
		while (wrCnt < n && k < 200)
		begin
			@(posedge clk);
			k++;
		end
		check(wrCnt, n);
	endtask
	task giveVerdict;
		$display("tests %0d errors %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		numErrors++;
		giveVerdict;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check({ringOscEn, lowPower}, 32'h0000_0002);
		repeat (20) @(posedge clk);
		check({ringOscEn, lowPower}, 32'h0000_0001);
		cmdMode <= 1'b1;
		repeat (3) @(posedge clk);
		check(ringOscEn, 32'h0000_0001);
		cmdMode <= 1'b0;
		apb(1'b0, `REG_FORM_BYTE, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, `REG_INTERVAL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		check(lastErr, 32'h0000_0001);
		apb(1'b1, `REG_INTERVAL, 32'h0000_FFFF);
		apb(1'b0, `REG_INTERVAL, 32'h0000_0000);
		check(rd, 32'h0000_8000);
		apb(1'b1, `REG_INTERVAL, 32'h0000_0000);
		apb(1'b1, `REG_CTRL, 32'h0000_005D);
		repeat (3) @(posedge clk);
		check({rtOscRun, extCmpRun, dinPullup}, 32'h0000_0007);
		apb(1'b0, `REG_STATUS, 32'h0000_0000);
		check(rd[0], 32'h0000_0000);
		press;
		repeat (8) @(posedge clk);
		apb(1'b0, `REG_STATUS, 32'h0000_0000);
		check({rd[0], wrCnt[3:0]}, 32'h0000_0010);
		press;
		waitWr(1);
		check({logBitAddr, logBitLen, logWidth10}, {14'd32, 7'd16, 1'b0});
		check({sawB, sawM, sawBoth}, 32'h0000_0007);
		press;
		repeat (8) @(posedge clk);
		press;
		waitWr(3);
		check(logBitAddr, 32'd64);
		repeat (60) @(posedge clk);
		check(wrCnt, 32'd3);
		apb(1'b1, `REG_FORM_BYTE, 32'h0000_0010);
		press;
		waitWr(4);
		check({logSrc, logWidth10, logBitLen, logBitAddr}, {2'b10, 1'b1, 7'd52, 14'd80});
		@(posedge clk);
		extIrq <= 1'b1;
		@(posedge clk);
		extIrq <= 1'b0;
		waitWr(5);
		check({logSrc, logBitAddr}, {2'b01, 14'd132});
		apb(1'b1, `REG_FORM_BYTE, 32'h0000_0020);
		press;
		repeat (60) @(posedge clk);
		check(wrCnt, 32'd5);
		tempLimit <= 3'b100;
		press;
		waitWr(6);
		check({logBitLen, logStamp}, {7'd36, 16'd6});
		apb(1'b1, `REG_FORM_BYTE, 32'h0000_0030);
		press;
		repeat (60) @(posedge clk);
		check(wrCnt, 32'd6);
		tempLimit <= 3'b000;
		press;
		waitWr(7);
		check({logBitLen, logBitAddr}, {7'd36, 14'd220});
		apb(1'b1, `REG_FORM_BYTE, 32'h0000_0000);
		apb(1'b1, `REG_STORE_BYTE, 32'h0000_0000);
		repeat (6)
		begin
			press;
			repeat (50) @(posedge clk);
		end
		apb(1'b0, `REG_STATUS, 32'h0000_0000);
		check(rd[3], 32'h0000_0001);
		apb(1'b0, `REG_POINTER, 32'h0000_0000);
		check(rd, 32'h0000_0140);
		press;
		repeat (50) @(posedge clk);
		apb(1'b0, `REG_POINTER, 32'h0000_0000);
		check(rd, 32'h0000_0140);
		apb(1'b1, `REG_INTERVAL, 32'h0000_0002);
		repeat (90) @(posedge clk);
		check(logSrc, `SRC_TIMER);
		apb(1'b1, `REG_INTERVAL, 32'h0000_0000);
		apb(1'b1, `REG_CTRL, 32'h0000_005E);
		apb(1'b1, `REG_DELAY, 32'h0000_0001);
		apb(1'b1, `REG_CTRL, 32'h0000_005D);
		repeat (512 * 20 - 60) @(posedge clk);
		apb(1'b0, `REG_STATUS, 32'h0000_0000);
		check(rd[0], 32'h0000_0000);
		repeat (100) @(posedge clk);
		apb(1'b0, `REG_STATUS, 32'h0000_0000);
		check(rd[0], 32'h0000_0001);
		giveVerdict;
	end
endmodule
